// ---- core/mfi_pkg.sv ----
// Package for the multi-function input decoder: codes, widths, timing.
// Assumes a 200 MHz system clock and eight contact input terminals.
package mfi_pkg;
  localparam int NUM_IN = 8;
  localparam int TW = 3;                 // Terminal index width
  localparam int CW = 8;                 // Function code width
  localparam int FW = 16;                // Frequency word width
  localparam int DW = 16;                // Delay setting width (ticks)
  // Function codes
  localparam logic [7:0] F_RAMP_HOLD = 8'h0A;
  localparam logic [7:0] F_MOP_UP = 8'h10;
  localparam logic [7:0] F_MOP_DN = 8'h11;
  localparam logic [7:0] F_FSTOP_NO = 8'h15;
  localparam logic [7:0] F_MOTOR2 = 8'h16;
  localparam logic [7:0] F_FSTOP_NC = 8'h17;
  localparam logic [7:0] F_TIMER = 8'h18;
  localparam logic [7:0] F_PID_OFF = 8'h19;
  localparam logic [7:0] F_WR_EN = 8'h1B;
  localparam logic [7:0] F_TRIM_UP = 8'h1C;
  localparam logic [7:0] F_TRIM_DN = 8'h1D;
  localparam logic [7:0] F_SAMPLE = 8'h1E;
  localparam logic [3:0] EF_HI = 4'h2;   // Upper nibble of fault codes
  localparam int EF_NC_BIT = 0;          // Normally closed contact
  localparam int EF_RUN_BIT = 1;         // Detected only while running
  localparam int EF_ACT_LSB = 2;         // Stop method field
  localparam logic [1:0] ACT_DECEL = 2'h0;
  localparam logic [1:0] ACT_COAST = 2'h1;
  localparam logic [1:0] ACT_FAST = 2'h2;
  localparam logic [1:0] ACT_MINOR = 2'h3;
  // Timebase: one tick per millisecond
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [17:0] TICK_MAX = 18'(TICK_CYC - 1);
  localparam int HOLD_MS = 100;
  localparam logic [DW-1:0] HOLD_TICKS = DW'(HOLD_MS * 1000 / TICK_US);
  typedef enum logic [1:0] {
    MFI_IDLE = 2'b00, MFI_RUN = 2'b01, MFI_FSTOP = 2'b11, MFI_WAIT = 2'b10
  } mfi_run_t;
  typedef struct packed {
    logic valid;
    logic [TW-1:0] terminal;
    logic [1:0] action;
  } mfi_fault_t;
  typedef struct packed {
    logic [FW-1:0] reference;
    logic [FW-1:0] analog;
    logic [FW-1:0] trim;
    logic panel_src;
  } mfi_freq_t;
endpackage

// ---- core/mfi_decoder.sv ----
// Multi-function input decoder: maps contact terminals to drive actions.
// Assumes contacts are asynchronous pins; settings are static-ish ports.

// Behaviour
// - Fast stop input decelerates using fast stop time
// - Run refused while fast stop asserted
// - Code 16 closed selects second motor set
// - Timer runs independently, code 18 in
// - Timer closes after on-delay continuous closure
// - Timer opens after off-delay continuous opening
// - Code 19 bypasses PID while closed
// - Lockout open blocks writes except reference
// - Lone trim up or down is config error
// - Trim adds or subtracts trim amount
// - Trim ignored with panel reference source
// - Sample analog after 100 ms hold
// - Sample-hold conflicts raise config error
// - Power cycle clears held reference
// - Codes 20-2F are external faults, terminal
// - Even codes NO, odd codes NC
// - Bit 1 set means detect only running
// - Fault code selects stop method or minor
module mfi_decoder (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [mfi_pkg::NUM_IN-1:0] i_contact,
  input wire logic [mfi_pkg::NUM_IN*mfi_pkg::CW-1:0] i_func_sel,
  input wire logic i_run_cmd,
  input wire logic i_pid_mode_select,
  input wire logic [mfi_pkg::DW-1:0] i_timer_on_delay,
  input wire logic [mfi_pkg::DW-1:0] i_timer_off_delay,
  input wire mfi_pkg::mfi_freq_t i_freq,
  input wire logic i_param_wr_req,
  input wire logic i_param_is_freq_ref,
  output logic o_run_enable,
  output logic o_fast_stop_decel,
  output logic o_motor2_select,
  output logic o_timer_output,
  output logic o_pid_bypass,
  output logic o_param_wr_accept,
  output logic [mfi_pkg::FW-1:0] o_freq_command,
  output logic o_input_config_conflict_error,
  output mfi_pkg::mfi_fault_t o_external_fault_indication
);
  localparam int N = mfi_pkg::NUM_IN;
  logic [N-1:0] sync1_q, sync2_q;
  logic [17:0] tick_cnt_q;
  logic tick;
  // Per-terminal decode flags
  logic [N-1:0] is_fs_no, is_fs_nc, is_m2, is_tmr, is_pid, is_wr;
  logic [N-1:0] is_tu, is_td, is_sh, is_rh, is_mop, is_ef, ef_hit;
  logic [N-1:0] fs_act, m2_act, tmr_act, pid_act, wr_act, tu_act, td_act;
  logic [N-1:0] sh_act;

  // Input synchronisers
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= i_contact;
      sync2_q <= sync1_q;
    end

  // Shared millisecond timebase
  assign tick = (tick_cnt_q == mfi_pkg::TICK_MAX);
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 18'h00001;

  // Per-terminal function decode
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_dec
      logic [7:0] c;
      logic ef_raw;
      assign c = i_func_sel[g*mfi_pkg::CW +: mfi_pkg::CW];
      assign is_fs_no[g] = (c == mfi_pkg::F_FSTOP_NO);
      assign is_fs_nc[g] = (c == mfi_pkg::F_FSTOP_NC);
      assign is_m2[g] = (c == mfi_pkg::F_MOTOR2);
      assign is_tmr[g] = (c == mfi_pkg::F_TIMER);
      assign is_pid[g] = (c == mfi_pkg::F_PID_OFF);
      assign is_wr[g] = (c == mfi_pkg::F_WR_EN);
      assign is_tu[g] = (c == mfi_pkg::F_TRIM_UP);
      assign is_td[g] = (c == mfi_pkg::F_TRIM_DN);
      assign is_sh[g] = (c == mfi_pkg::F_SAMPLE);
      assign is_rh[g] = (c == mfi_pkg::F_RAMP_HOLD);
      assign is_mop[g] = (c == mfi_pkg::F_MOP_UP) ||
                         (c == mfi_pkg::F_MOP_DN);
      assign is_ef[g] = (c[7:4] == mfi_pkg::EF_HI);
      // Closed for NO, open for NC
      assign fs_act[g] = (is_fs_no[g] & sync2_q[g]) |
                         (is_fs_nc[g] & ~sync2_q[g]);
      assign m2_act[g] = is_m2[g] & sync2_q[g];
      assign tmr_act[g] = is_tmr[g] & sync2_q[g];
      assign pid_act[g] = is_pid[g] & sync2_q[g];
      assign wr_act[g] = is_wr[g] & sync2_q[g];
      assign tu_act[g] = is_tu[g] & sync2_q[g];
      assign td_act[g] = is_td[g] & sync2_q[g];
      assign sh_act[g] = is_sh[g] & sync2_q[g];
      assign ef_raw = c[mfi_pkg::EF_NC_BIT] ? ~sync2_q[g] : sync2_q[g];
      assign ef_hit[g] = is_ef[g] & ef_raw &
        (~c[mfi_pkg::EF_RUN_BIT] | o_run_enable);
    end
  endgenerate

  // Fast stop and run gating
  logic fs_any;
  mfi_pkg::mfi_run_t st_q, st_d;
  assign fs_any = |fs_act;
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      mfi_pkg::MFI_IDLE:
        if (i_run_cmd && !fs_any)
          st_d = mfi_pkg::MFI_RUN;
      mfi_pkg::MFI_RUN:
        if (fs_any)
          st_d = mfi_pkg::MFI_FSTOP;
        else if (!i_run_cmd)
          st_d = mfi_pkg::MFI_IDLE;
      mfi_pkg::MFI_FSTOP:
        if (!fs_any)
          st_d = mfi_pkg::MFI_WAIT;
      default:
        if (fs_any)
          st_d = mfi_pkg::MFI_FSTOP;
        else if (!i_run_cmd)
          st_d = mfi_pkg::MFI_IDLE;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      st_q <= mfi_pkg::MFI_IDLE;
    else
      st_q <= st_d;
  assign o_run_enable = (st_q == mfi_pkg::MFI_RUN) && !fs_any;
  assign o_fast_stop_decel = (st_q == mfi_pkg::MFI_FSTOP);

  // Simple level functions
  assign o_motor2_select = |m2_act;
  assign o_pid_bypass = i_pid_mode_select & (|pid_act);
  assign o_param_wr_accept = i_param_wr_req &
    (i_param_is_freq_ref | ~(|is_wr) | (|wr_act));

  // Configuration conflict check
  logic trim_pair_bad, sh_conflict;
  assign trim_pair_bad = (|is_tu) ^ (|is_td);
  assign sh_conflict = (|is_sh) &
    ((|is_rh) | (|is_mop) | (|is_tu) | (|is_td));
  assign o_input_config_conflict_error = trim_pair_bad | sh_conflict;

  // Timer function with on and off delays
  logic tmr_in, tmr_out_q;
  logic [mfi_pkg::DW-1:0] tmr_cnt_q;
  assign tmr_in = |tmr_act;
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      tmr_cnt_q <= '0;
      tmr_out_q <= 1'b0;
    end
    else if (tmr_in == tmr_out_q)
      tmr_cnt_q <= '0;
    else if (tmr_in && tmr_cnt_q >= i_timer_on_delay)
    begin
      tmr_out_q <= 1'b1;
      tmr_cnt_q <= '0;
    end
    else if (!tmr_in && tmr_cnt_q >= i_timer_off_delay)
    begin
      tmr_out_q <= 1'b0;
      tmr_cnt_q <= '0;
    end
    else if (tick)
      tmr_cnt_q <= tmr_cnt_q + 1'b1;
  assign o_timer_output = tmr_out_q;

  // Sample-hold: 100 ms hold loads analog reference
  logic sh_in, sh_done_q, sh_valid_q;
  logic [mfi_pkg::DW-1:0] sh_cnt_q;
  logic [mfi_pkg::FW-1:0] sh_ref_q;
  assign sh_in = |sh_act;
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      sh_cnt_q <= '0;
      sh_done_q <= 1'b0;
      sh_valid_q <= 1'b0;
      sh_ref_q <= '0;
    end
    else if (!sh_in)
    begin
      sh_cnt_q <= '0;
      sh_done_q <= 1'b0;
    end
    else if (!sh_done_q && sh_cnt_q >= mfi_pkg::HOLD_TICKS)
    begin
      sh_ref_q <= i_freq.analog;
      sh_valid_q <= 1'b1;
      sh_done_q <= 1'b1;
    end
    else if (tick && !sh_done_q)
      sh_cnt_q <= sh_cnt_q + 1'b1;

  // Frequency command with trim
  logic [mfi_pkg::FW-1:0] base_ref, freq_d, freq_q;
  logic trim_ok, up, dn;
  assign base_ref = (|is_sh) ? (sh_valid_q ? sh_ref_q : '0)
                             : i_freq.reference;
  assign trim_ok = ~i_freq.panel_src & ~trim_pair_bad;
  assign up = trim_ok & (|tu_act) & ~(|td_act);
  assign dn = trim_ok & (|td_act) & ~(|tu_act);
  assign freq_d = up ? base_ref + i_freq.trim :
                  dn ? base_ref - i_freq.trim : base_ref;
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      freq_q <= '0;
    else
      freq_q <= freq_d;
  assign o_freq_command = freq_q;

  // External fault: lowest terminal wins, latched until no fault input is active
  logic [mfi_pkg::TW-1:0] ef_term;
  logic [1:0] ef_act;
  always_comb
  begin
    ef_term = '0;
    ef_act = mfi_pkg::ACT_DECEL;
    for (int k = N - 1; k >= 0; k--)
      if (ef_hit[k])
      begin
        ef_term = mfi_pkg::TW'(k);
        ef_act = i_func_sel[k*mfi_pkg::CW + mfi_pkg::EF_ACT_LSB +: 2];
      end
  end
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      o_external_fault_indication <= '0;
    else if (!o_external_fault_indication.valid && (|ef_hit))
      o_external_fault_indication <= '{1'b1, ef_term, ef_act};
    else if (!(|ef_hit))
      o_external_fault_indication.valid <= 1'b0;
endmodule

// ---- bench/mfi_decoder_sva.sv ----
// Checker for the input decoder, watching its ports only.
// Assumes it is bound into every instance of the decoder.
module mfi_decoder_sva (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [63:0] i_func_sel,
  input wire logic i_pid_mode_select,
  input wire logic i_param_wr_req,
  input wire logic i_param_is_freq_ref,
  input wire logic o_run_enable,
  input wire logic o_fast_stop_decel,
  input wire logic o_motor2_select,
  input wire logic o_pid_bypass,
  input wire logic o_param_wr_accept,
  input wire logic o_input_config_conflict_error,
  input wire mfi_pkg::mfi_fault_t o_external_fault_indication
);
  mfi_pkg::mfi_fault_t ef;
  logic [7:0] fcode;
  // Code of the terminal named in the fault report
  assign ef = o_external_fault_indication;
  assign fcode = i_func_sel[8*ef.terminal +: 8];
  // True when any terminal carries the given code
  function automatic logic has(input logic [7:0] c);
    has = 1'b0;
    for (int k = 0; k < 8; k++)
      if (i_func_sel[8*k +: 8] == c) has = 1'b1;
  endfunction
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Relations between settings, write requests and outputs
  property p_fs; o_fast_stop_decel |-> !o_run_enable; endproperty
  a_fs: assert property (p_fs) else $error("run during fast stop");
  property p_fsr; $fell(o_fast_stop_decel) |-> !o_run_enable; endproperty
  a_fsr: assert property (p_fsr) else $error("run at release");
  property p_wr; i_param_wr_req && i_param_is_freq_ref |-> o_param_wr_accept;
  endproperty
  a_wr: assert property (p_wr) else $error("reference write lost");
  property p_trim; (has(mfi_pkg::F_TRIM_UP) != has(mfi_pkg::F_TRIM_DN))
    |-> o_input_config_conflict_error; endproperty
  a_trim: assert property (p_trim) else $error("lone trim");
  property p_samp; has(mfi_pkg::F_SAMPLE) && (has(mfi_pkg::F_RAMP_HOLD) ||
    has(mfi_pkg::F_MOP_UP) || has(mfi_pkg::F_MOP_DN) ||
    has(mfi_pkg::F_TRIM_UP) || has(mfi_pkg::F_TRIM_DN))
    |-> o_input_config_conflict_error; endproperty
  a_samp: assert property (p_samp) else $error("sample conflict");
  property p_pid; o_pid_bypass |-> i_pid_mode_select && has(mfi_pkg::F_PID_OFF);
  endproperty
  a_pid: assert property (p_pid) else $error("bad pid bypass");
  property p_m2; o_motor2_select |-> has(mfi_pkg::F_MOTOR2); endproperty
  a_m2: assert property (p_m2) else $error("motor2 unset");
  property p_ef; ef.valid |-> fcode[7:4] == mfi_pkg::EF_HI &&
    ef.action == fcode[3:2]; endproperty
  a_ef: assert property (p_ef) else $error("bad fault report");
endmodule

bind mfi_decoder mfi_decoder_sva u_sva (.i_clk, .i_reset_n, .i_func_sel,
  .i_pid_mode_select, .i_param_wr_req, .i_param_is_freq_ref, .o_run_enable,
  .o_fast_stop_decel, .o_motor2_select, .o_pid_bypass, .o_param_wr_accept,
  .o_input_config_conflict_error, .o_external_fault_indication);

// ---- bench/mfi_contact_model.sv ----
// Model of the switches and relays wired to the input terminals.
// Assumes the bench sets levels; a closed contact reads as 1.
module mfi_contact_model (
  input wire logic i_clk,
  input wire logic [7:0] i_level,
  output logic [7:0] o_contact = 8'h00
);
  timeunit 1ns;
  timeprecision 100ps;
  // Contacts move a little after the edge, never on it
  always @(posedge i_clk)
    o_contact <= #1 i_level;
endmodule

// ---- bench/tb_top.sv ----
// Bench: drives settings and contacts, compares decoder outputs.
// Assumes the contact model and the checker bind are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] lvl = 8'h00;
  logic [7:0] i_contact;
  logic [63:0] i_func_sel = {8{8'h0F}};
  logic i_run_cmd = 1'b0;
  logic i_pid_mode_select = 1'b0;
  logic i_param_wr_req = 1'b0;
  logic i_param_is_freq_ref = 1'b0;
  logic [15:0] i_timer_on_delay = 16'h0005;
  logic [15:0] i_timer_off_delay = 16'h0005;
  mfi_pkg::mfi_freq_t i_freq = '{16'h0100, 16'h1234, 16'h0010, 1'b0};
  logic o_run_enable, o_fast_stop_decel, o_motor2_select, o_timer_output;
  logic o_pid_bypass, o_param_wr_accept, o_input_config_conflict_error;
  logic [15:0] fc;
  mfi_pkg::mfi_fault_t ef;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  mfi_contact_model u_con (.i_clk, .i_level(lvl), .o_contact(i_contact));
  mfi_decoder DUT (.i_clk, .i_reset_n, .i_contact, .i_func_sel, .i_run_cmd,
    .i_pid_mode_select, .i_timer_on_delay, .i_timer_off_delay, .i_freq,
    .i_param_wr_req, .i_param_is_freq_ref, .o_run_enable, .o_fast_stop_decel,
    .o_motor2_select, .o_timer_output, .o_pid_bypass, .o_param_wr_accept,
    .o_freq_command(fc), .o_input_config_conflict_error,
    .o_external_fault_indication(ef));
  // Free-running 200 MHz clock
  initial forever #2.5 i_clk = ~i_clk;
  // Cycle ceiling against a hung run
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      final_report();
    end
  end
  // Bench helpers: timing, compares, reset and setup
  task step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task chkw(input logic [15:0] a, input logic [15:0] e, input string m);
    check_count++;
    if (a !== e)
    begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, m, a, e);
    end
  endtask
  task chkb(input logic a, input logic e, input string m);
    chkw({15'h0, a}, {15'h0, e}, m);
  endtask
  task final_report();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task hold();
    i_reset_n = 1'b0;
    i_func_sel = {8{8'h0F}};
    lvl = 8'h00;
    i_run_cmd = 1'b0;
    step(2);
  endtask
  task cfg(input int t, input logic [7:0] c);
    i_func_sel[8*t +: 8] = c;
  endtask
  // Main sequence
  initial
  begin
    hold();
    step(18);
    i_reset_n = 1'b1;
    step(2);
    chkb(o_run_enable, 1'b0, "run after reset");
    cfg(1, mfi_pkg::F_TRIM_UP);
    step(1);
    chkb(o_input_config_conflict_error, 1'b1, "lone trim");
    cfg(2, mfi_pkg::F_TRIM_DN);
    step(1);
    chkb(o_input_config_conflict_error, 1'b0, "trim pair");
    cfg(3, mfi_pkg::F_SAMPLE);
    for (int k = 0; k < 4; k++)
    begin
      cfg(1, k[0] ? mfi_pkg::F_RAMP_HOLD : mfi_pkg::F_MOP_UP);
      cfg(2, k[1] ? mfi_pkg::F_MOP_DN : mfi_pkg::F_TRIM_DN);
      step(1);
      chkb(o_input_config_conflict_error, 1'b1, "sample clash");
    end
    for (int i = 0; i < 2; i++)
    begin
      hold();
      cfg(0, i[0] ? mfi_pkg::F_FSTOP_NC : mfi_pkg::F_FSTOP_NO);
      lvl = {7'h0, i[0]};
      i_reset_n = 1'b1;
      i_run_cmd = 1'b1;
      step(5);
      chkb(o_run_enable, 1'b1, "run");
      lvl[0] = ~lvl[0];
      step(5);
      chkb(o_fast_stop_decel, 1'b1, "fast stop");
      chkb(o_run_enable, 1'b0, "run refused");
      lvl[0] = ~lvl[0];
      step(5);
      chkb(o_run_enable, 1'b0, "run still held");
      i_run_cmd = 1'b0;
      step(3);
      i_run_cmd = 1'b1;
      step(5);
      chkb(o_run_enable, 1'b1, "restart");
    end
    for (int c = 32; c < 48; c++)
    begin
      hold();
      cfg(3, 8'(c));
      lvl = c[0] ? 8'h00 : 8'h08;
      i_reset_n = 1'b1;
      step(6);
      if (c[1])
      begin
        chkb(ef.valid, 1'b0, "run-only fault");
        i_run_cmd = 1'b1;
        step(4);
        chkw(16'(ef), {10'h0, 4'hB, c[3:2]}, "fault in run");
      end
      else
        chkw(16'(ef), {10'h0, 4'hB, c[3:2]}, "fault");
      lvl = lvl ^ 8'h08;
      step(6);
      chkb(ef.valid, 1'b0, "fault gone");
    end
    hold();
    cfg(0, mfi_pkg::F_SAMPLE);
    i_reset_n = 1'b1;
    lvl = 8'h01;
    step(50);
    lvl = 8'h00;
    step(6);
    chkw(fc, 16'h0000, "short sample");
    hold();
    cfg(1, mfi_pkg::F_TRIM_UP);
    cfg(2, mfi_pkg::F_TRIM_DN);
    cfg(4, mfi_pkg::F_MOTOR2);
    cfg(5, mfi_pkg::F_WR_EN);
    cfg(6, mfi_pkg::F_PID_OFF);
    cfg(7, mfi_pkg::F_TIMER);
    i_reset_n = 1'b1;
    lvl = 8'h02;
    step(6);
    chkw(fc, 16'h0110, "trim up");
    lvl = 8'h04;
    step(6);
    chkw(fc, 16'h00F0, "trim down");
    i_freq.panel_src = 1'b1;
    step(6);
    chkw(fc, 16'h0100, "panel source");
    i_freq.panel_src = 1'b0;
    lvl = 8'h00;
    i_pid_mode_select = 1'b1;
    i_param_wr_req = 1'b1;
    step(6);
    chkw(fc, 16'h0100, "trim released");
    chkb(o_param_wr_accept, 1'b0, "locked write");
    i_param_is_freq_ref = 1'b1;
    step(1);
    chkb(o_param_wr_accept, 1'b1, "reference write");
    i_param_is_freq_ref = 1'b0;
    lvl = 8'hF0;
    step(40);
    chkb(o_param_wr_accept, 1'b1, "unlocked write");
    chkb(o_motor2_select, 1'b1, "motor2");
    chkb(o_pid_bypass, 1'b1, "pid bypass");
    chkb(o_timer_output, 1'b0, "short timer start");
    i_timer_on_delay = 16'h0000;
    step(2);
    chkb(o_timer_output, 1'b1, "zero on-delay");
    i_pid_mode_select = 1'b0;
    lvl = 8'h00;
    step(6);
    chkb(o_timer_output, 1'b1, "off delay holds");
    i_timer_off_delay = 16'h0000;
    step(2);
    chkb(o_timer_output, 1'b0, "zero off-delay");
    chkb(o_pid_bypass, 1'b0, "pid off");
    chkb(o_motor2_select, 1'b0, "motor1");
    final_report();
  end
endmodule
